// ---- src/axis_homing_sequencer.sv ----
/*
 * homing sequencer for one motion axis, modes 17 to 27.
 * assumes the drive follows direction, speed select and move level, and
 * that the position counter clears on the origin pulse.
 */
// Operation
// - run only the selected numbered mode
// - mode 17 homes on reverse limit
// - mode 18 homes on forward limit
// - mode 19 forward search, reverse home
// - mode 20 homes where switch rises
// - mode 21 reverse search, forward home
// - mode 22 homes on rising switch
// - mode 23 forward search, reverse home
// - mode 23 forward limit reverses fast
// - mode 24 as 20, limit recovery
// - mode 25 low: pass zone, return
// - mode 25 high, limit reverses fast
// - mode 26 forward home, limit recovery
// - mode 27 reverse search, forward home
// - mode 27 reverse limit goes forward
`timescale 1ns/100ps
`default_nettype none
`include "homing_defs.svh"

module axis_homing_sequencer (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // operator command
   input wire logic i_homing_command,
   input wire logic [`MODE_W-1:0] i_mode,
   // switch pins
   input wire logic i_home_sw,
   input wire logic i_fwd_limit,
   input wire logic i_rev_limit,
   // drive commands
   output logic o_move,
   output logic o_dir,
   output logic o_speed_sel,
   // status
   output logic o_busy,
   output logic o_home_done,
   output logic o_mode_error,
   output logic o_origin_return,
   output homing_pkg::stage_t o_stage
);
   import homing_pkg::*;

   // ----------------------------------------
   // switch conditioning
   // ----------------------------------------
   logic h;
   logic fl;
   logic rl;

   switch_filter u_home_filt (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_pin(i_home_sw),
      .o_level(h));
   switch_filter u_fwd_filt (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_pin(i_fwd_limit),
      .o_level(fl));
   switch_filter u_rev_filt (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_pin(i_rev_limit),
      .o_level(rl));

   // ----------------------------------------
   // motion profile per mode and stage: {forward, first speed}
   // ----------------------------------------
   function automatic logic [1:0] profile(input logic [`MODE_W-1:0] m, input stage_t s);
      logic [1:0] p;
      p = {`DIR_FWD, `SPEED_SECOND};
      case (m)
         `MODE_17: p = (s == ST_S1) ? {`DIR_REV, `SPEED_FIRST} : {`DIR_FWD, `SPEED_SECOND};
         `MODE_18, `MODE_19, `MODE_23: begin
            case (s)
               ST_S1: p = {`DIR_FWD, `SPEED_FIRST};
               ST_S3: p = {`DIR_REV, `SPEED_FIRST};
               default: p = {`DIR_REV, `SPEED_SECOND};
            endcase
         end
         `MODE_20: begin
            case (s)
               ST_S1: p = {`DIR_FWD, `SPEED_FIRST};
               ST_S2: p = {`DIR_REV, `SPEED_SECOND};
               default: p = {`DIR_FWD, `SPEED_SECOND};
            endcase
         end
         `MODE_21, `MODE_27: begin
            case (s)
               ST_S1: p = {`DIR_REV, `SPEED_FIRST};
               ST_S3: p = {`DIR_FWD, `SPEED_FIRST};
               default: p = {`DIR_FWD, `SPEED_SECOND};
            endcase
         end
         `MODE_22: begin
            case (s)
               ST_S1: p = {`DIR_FWD, `SPEED_SECOND};
               ST_S2: p = {`DIR_REV, `SPEED_SECOND};
               default: p = {`DIR_REV, `SPEED_FIRST};
            endcase
         end
         `MODE_24: begin
            case (s)
               ST_S1, ST_S5: p = {`DIR_FWD, `SPEED_FIRST};
               ST_S2: p = {`DIR_REV, `SPEED_SECOND};
               ST_S3, ST_S4: p = {`DIR_REV, `SPEED_FIRST};
               default: p = {`DIR_FWD, `SPEED_SECOND};
            endcase
         end
         `MODE_25: begin
            case (s)
               ST_S1: p = {`DIR_FWD, `SPEED_FIRST};
               ST_S2: p = {`DIR_FWD, `SPEED_SECOND};
               ST_S3: p = {`DIR_REV, `SPEED_SECOND};
               default: p = {`DIR_REV, `SPEED_FIRST};
            endcase
         end
         `MODE_26: begin
            case (s)
               ST_S1: p = {`DIR_FWD, `SPEED_FIRST};
               ST_S3: p = {`DIR_REV, `SPEED_FIRST};
               default: p = {`DIR_FWD, `SPEED_SECOND};
            endcase
         end
         default: p = {`DIR_FWD, `SPEED_SECOND};
      endcase
      return p;
   endfunction

   // ----------------------------------------
   // state
   // ----------------------------------------
   stage_t stage_reg;
   stage_t stage_next;
   logic [`MODE_W-1:0] mode_reg;
   logic hit;
   logic move_reg;
   logic dir_reg;
   logic speed_reg;
   logic done_reg;
   logic err_reg;
   logic origin_reg;

   wire idle = (stage_reg == ST_IDLE);
   wire mode_ok = (i_mode >= `MODE_17) && (i_mode <= `MODE_27);
   wire start = idle && i_homing_command && mode_ok;
   wire bad_start = idle && i_homing_command && !mode_ok;
   // the mode in force: the request while starting, the latched one after
   wire [`MODE_W-1:0] mode_use = start ? i_mode : mode_reg;
   // level that picks case 1 or 2 at command time
   wire start_sw = (i_mode == `MODE_17) ? rl : (i_mode == `MODE_18) ? fl : h;
   wire [1:0] prof_next = profile(mode_use, stage_next);

   // ----------------------------------------
   // stage sequencing
   // ----------------------------------------
   always_comb begin
      stage_next = stage_reg;
      hit = 1'b0;
      if (idle) begin
         if (start) begin
            if (i_mode == `MODE_22) begin
               stage_next = start_sw ? ST_S1 : ST_S3;
            end else begin
               stage_next = start_sw ? ST_S2 : ST_S1;
            end
         end
      end else begin
         case (mode_reg)
            `MODE_17: begin
               if (stage_reg == ST_S1) begin
                  if (rl) stage_next = ST_S2;
               end else if (!rl) hit = 1'b1;
            end
            `MODE_18: begin
               if (stage_reg == ST_S1) begin
                  if (fl) stage_next = ST_S2;
               end else if (!fl) hit = 1'b1;
            end
            `MODE_19, `MODE_23: begin
               case (stage_reg)
                  ST_S1: begin
                     if (h) stage_next = ST_S2;
                     else if (fl && mode_reg == `MODE_23) stage_next = ST_S3;
                  end
                  ST_S3: if (h) stage_next = ST_S2;
                  default: if (!h) hit = 1'b1;
               endcase
            end
            `MODE_20: begin
               case (stage_reg)
                  ST_S2: if (!h) stage_next = ST_S3;
                  default: if (h) hit = 1'b1;
               endcase
            end
            `MODE_21, `MODE_27: begin
               case (stage_reg)
                  ST_S1: begin
                     if (h) stage_next = ST_S2;
                     else if (rl && mode_reg == `MODE_27) stage_next = ST_S3;
                  end
                  ST_S3: if (h) stage_next = ST_S2;
                  default: if (!h) hit = 1'b1;
               endcase
            end
            `MODE_22: begin
               case (stage_reg)
                  ST_S1: if (!h) stage_next = ST_S2;
                  default: if (h) hit = 1'b1;
               endcase
            end
            `MODE_24: begin
               case (stage_reg)
                  ST_S1: begin
                     if (h) hit = 1'b1;
                     else if (fl) stage_next = ST_S3;
                  end
                  ST_S2: if (!h) stage_next = ST_S6;
                  ST_S3: if (h) stage_next = ST_S4;
                  ST_S4: if (!h) stage_next = ST_S5;
                  default: if (h) hit = 1'b1;
               endcase
            end
            `MODE_25: begin
               case (stage_reg)
                  ST_S1: begin
                     if (h) stage_next = ST_S2;
                     else if (fl) stage_next = ST_S4;
                  end
                  ST_S2: begin
                     if (!h) stage_next = ST_S3;
                     else if (fl) stage_next = ST_S4;
                  end
                  default: if (h) hit = 1'b1;
               endcase
            end
            `MODE_26: begin
               case (stage_reg)
                  ST_S1: begin
                     if (h) stage_next = ST_S2;
                     else if (fl) stage_next = ST_S3;
                  end
                  ST_S3: if (h) stage_next = ST_S2;
                  default: if (!h) hit = 1'b1;
               endcase
            end
            default: stage_next = ST_IDLE;
         endcase
         if (hit) stage_next = ST_IDLE;
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         stage_reg <= ST_IDLE;
         mode_reg <= '0;
      end else begin
         stage_reg <= stage_next;
         if (start) mode_reg <= i_mode;
      end
   end

   // drive outputs follow the next stage so motion changes on the same edge
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         move_reg <= 1'b0;
         dir_reg <= `DIR_FWD;
         speed_reg <= `SPEED_SECOND;
         origin_reg <= 1'b0;
         done_reg <= 1'b0;
         err_reg <= 1'b0;
      end else begin
         move_reg <= (stage_next != ST_IDLE);
         dir_reg <= prof_next[1];
         speed_reg <= prof_next[0];
         origin_reg <= hit;
         done_reg <= hit | (done_reg & ~start & ~bad_start);
         err_reg <= bad_start | (err_reg & ~start);
      end
   end

   assign o_move = move_reg;
   assign o_dir = dir_reg;
   assign o_speed_sel = speed_reg;
   assign o_busy = move_reg;
   assign o_home_done = done_reg;
   assign o_mode_error = err_reg;
   assign o_origin_return = origin_reg;
   assign o_stage = stage_reg;

endmodule
`default_nettype wire

// ---- src/homing_defs.svh ----
/*
 * Constants of the axis homing sequencer: mode numbers, switch filter
 * timing and output codes.
 * Assumes inclusion by bare name from the design files that use it.
 */
`ifndef HOMING_DEFS_SVH
`define HOMING_DEFS_SVH

// ----------------------------------------
// homing mode numbers
// ----------------------------------------
`define MODE_W 6
`define MODE_17 6'h11
`define MODE_18 6'h12
`define MODE_19 6'h13
`define MODE_20 6'h14
`define MODE_21 6'h15
`define MODE_22 6'h16
`define MODE_23 6'h17
`define MODE_24 6'h18
`define MODE_25 6'h19
`define MODE_26 6'h1a
`define MODE_27 6'h1b

// ----------------------------------------
// switch filter timing
// ----------------------------------------
`define CLK_PERIOD_NS 10
`define DEBOUNCE_NS 10000
`define DEBOUNCE_CYCLES ((`DEBOUNCE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DEBOUNCE_W 11

// ----------------------------------------
// drive command codes
// ----------------------------------------
`define DIR_REV 1'b0
`define DIR_FWD 1'b1
`define SPEED_SECOND 1'b0
`define SPEED_FIRST 1'b1

`endif

// ---- src/homing_pkg.sv ----
/*
 * Types of the axis homing sequencer.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package homing_pkg;

   // search stage of the running mode; idle means no motion
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_S1 = 3'b001,
      ST_S2 = 3'b010,
      ST_S3 = 3'b011,
      ST_S4 = 3'b100,
      ST_S5 = 3'b101,
      ST_S6 = 3'b110
   } stage_t;

endpackage
`default_nettype wire

// ---- src/switch_filter.sv ----
/*
 * Synchroniser and debounce filter for one switch input.
 * Assumes the switch is asynchronous to i_clk and bounces for less than
 * the filter time.
 */
`timescale 1ns/100ps
`default_nettype none
`include "homing_defs.svh"

module switch_filter (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // raw switch pin
   input wire logic i_pin,
   // filtered level
   output logic o_level
);

   logic sync1_reg;
   logic sync2_reg;
   logic level_reg;
   logic [`DEBOUNCE_W-1:0] cnt_reg;
   logic [`DEBOUNCE_W-1:0] cnt_next;
   wire differs = (sync2_reg != level_reg);
   wire settled = (cnt_reg == `DEBOUNCE_W'(`DEBOUNCE_CYCLES - 1));

   // restart the count on any bounce; accept only a level held steady
   assign cnt_next = differs ? (settled ? '0 : cnt_reg + `DEBOUNCE_W'(1)) : '0;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         level_reg <= 1'b0;
         cnt_reg <= '0;
      end else begin
         sync1_reg <= i_pin;
         sync2_reg <= sync1_reg;
         cnt_reg <= cnt_next;
         if (differs && settled) begin
            level_reg <= sync2_reg;
         end
      end
   end

   assign o_level = level_reg;

endmodule
`default_nettype wire

// ---- tb/axis_homing_sequencer_properties.sv ----
/* port checker for the homing sequencer, bound to its top module.
   assumes switch pins held steady for the filter time before a command. */
`timescale 1ns/100ps
`default_nettype none
`include "homing_defs.svh"
module axis_homing_props (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // command and switches
   input wire logic i_homing_command,
   input wire logic [`MODE_W-1:0] i_mode,
   input wire logic i_home_sw,
   input wire logic i_fwd_limit,
   input wire logic i_rev_limit,
   // drive and status
   input wire logic o_move,
   input wire logic o_dir,
   input wire logic o_speed_sel,
   input wire logic o_busy,
   input wire logic o_home_done,
   input wire logic o_mode_error,
   input wire logic o_origin_return,
   input wire homing_pkg::stage_t o_stage
);
   import homing_pkg::*;
   wire logic ok_mode;
   assign ok_mode = i_mode >= `MODE_17 && i_mode <= `MODE_27;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);
   // ----
   // start and home steps
   // ----
   sequence s_take(m, sw);
      !o_busy && i_homing_command && i_mode == m && sw;
   endsequence
   sequence s_home;
      o_origin_return ##1 !o_origin_return;
   endsequence
   a_start_moves: assert property (!o_busy && i_homing_command && ok_mode |=> o_move)
      else $error("valid command did not start motion");
   a_bad_mode: assert property (!o_busy && i_homing_command && !ok_mode |=> o_mode_error && !o_move)
      else $error("bad mode not refused");
   a_m17_start: assert property (s_take(`MODE_17, !i_rev_limit) |=> !o_dir && o_speed_sel)
      else $error("mode 17 wrong first leg");
   a_m19_start: assert property (s_take(`MODE_19, !i_home_sw) |=> o_dir && o_speed_sel)
      else $error("mode 19 wrong first leg");
   a_m20_start: assert property (s_take(`MODE_20, i_home_sw) |=> !o_dir && !o_speed_sel)
      else $error("mode 20 wrong first leg");
   a_m22_start: assert property (s_take(`MODE_22, !i_home_sw) |=> !o_dir && o_speed_sel)
      else $error("mode 22 wrong first leg");
   a_m23_start: assert property (s_take(`MODE_23, !i_home_sw) |=> o_dir && o_speed_sel)
      else $error("mode 23 wrong first leg");
   a_origin_once: assert property (o_origin_return |-> s_home)
      else $error("origin pulse not one cycle");
   a_home_stops: assert property ($fell(o_move) |-> o_origin_return && o_home_done && o_stage == ST_IDLE)
      else $error("stop without origin and done");
   a_leg_steady: assert property (o_move && $stable(o_stage) |-> $stable(o_dir) && $stable(o_speed_sel))
      else $error("drive changed within a stage");
endmodule
bind axis_homing_sequencer axis_homing_props u_props (.i_clk(i_clk), .i_rst_n(i_rst_n),
   .i_homing_command(i_homing_command), .i_mode(i_mode), .i_home_sw(i_home_sw),
   .i_fwd_limit(i_fwd_limit), .i_rev_limit(i_rev_limit), .o_move(o_move), .o_dir(o_dir),
   .o_speed_sel(o_speed_sel), .o_busy(o_busy), .o_home_done(o_home_done),
   .o_mode_error(o_mode_error), .o_origin_return(o_origin_return), .o_stage(o_stage));
`default_nettype wire

// ---- tb/axis_drive_model.sv ----
/* axis drive with home switch and both travel limits along one line.
   assumes first speed moves one unit a cycle, second speed half that. */
`timescale 1ns/100ps
`default_nettype none
module axis_drive_model #(
   parameter int REV_EDGE = 2000,
   parameter int HOME_LO = 6000,
   parameter int HOME_HI = 10000,
   parameter int FWD_EDGE = 14000
) (
   // clock
   input wire logic i_clk,
   // drive commands
   input wire logic i_move,
   input wire logic i_dir,
   input wire logic i_speed_sel,
   // position preset
   input wire logic i_load,
   input var int i_load_pos,
   // switch pins and position
   output logic o_home_sw,
   output logic o_fwd_limit,
   output logic o_rev_limit,
   output var int o_pos
);
   logic half_reg = 1'b0;
   initial o_pos = 0;
   // speeds are fixed here, as preset before any command
   always @(posedge i_clk) begin
      half_reg <= !half_reg;
      if (i_load) begin
         o_pos <= i_load_pos;
      end else if (i_move && (i_speed_sel || half_reg)) begin
         o_pos <= o_dir_step(i_dir, o_pos);
      end
   end
   function automatic int o_dir_step(input logic d, input int p);
      return d ? p + 1 : p - 1;
   endfunction
   // switch zones; levels are steady so the design's filter sees them
   assign o_home_sw = o_pos >= HOME_LO && o_pos <= HOME_HI;
   assign o_fwd_limit = o_pos >= FWD_EDGE;
   assign o_rev_limit = o_pos <= REV_EDGE;
endmodule
`default_nettype wire

// ---- tb/axis_homing_sequencer_test.sv ----
/* bench for the homing sequencer: presets the axis, runs modes, checks stops.
   assumes the drive model stands in for motor and switches. */
`timescale 1ns/100ps
`default_nettype none
`include "homing_defs.svh"
module axis_homing_sequencer_test;
   import homing_pkg::*;
   logic i_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic cmd = 1'b0;
   logic [`MODE_W-1:0] mode = 6'h00;
   logic load = 1'b0;
   int load_pos = 0;
   int pos;
   int miscompares = 0;
   int comparisons = 0;
   wire logic home_sw, fwd_lim, rev_lim, mv, dir, spd, busy, done, err, org;
   stage_t stage;
   axis_drive_model model (.i_clk(i_clk), .i_move(mv), .i_dir(dir), .i_speed_sel(spd),
      .i_load(load), .i_load_pos(load_pos), .o_home_sw(home_sw), .o_fwd_limit(fwd_lim),
      .o_rev_limit(rev_lim), .o_pos(pos));
   axis_homing_sequencer DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_homing_command(cmd),
      .i_mode(mode), .i_home_sw(home_sw), .i_fwd_limit(fwd_lim), .i_rev_limit(rev_lim),
      .o_move(mv), .o_dir(dir), .o_speed_sel(spd), .o_busy(busy), .o_home_done(done),
      .o_mode_error(err), .o_origin_return(org), .o_stage(stage));
   initial begin
      forever #5 i_clk = ~i_clk;
   end
   task automatic end_of_test();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk_bit(input logic got, input logic exp, input string what);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t %s", $time, what);
      end
   endtask
   task automatic chk_pos(input int lo, input int hi);
      comparisons++;
      if (pos < lo || pos > hi) begin
         miscompares++;
         $display("[ERR] %0t home point %0d", $time, pos);
      end
   endtask
   task automatic issue(input logic [`MODE_W-1:0] m);
      @(negedge i_clk);
      cmd = 1'b1;
      mode = m;
      @(negedge i_clk);
      cmd = 1'b0;
   endtask
   // one homing from a preset point; d0/s0 first leg, d1/s1 last leg
   task automatic run_home(input logic [`MODE_W-1:0] m, input int p, input logic d0, s0,
      d1, s1, input int lo, hi);
      int n;
      logic ld, ls;
      @(negedge i_clk);
      load = 1'b1;
      load_pos = p;
      @(negedge i_clk);
      load = 1'b0;
      // switch filters need 1002 steady cycles
      repeat (1100) @(negedge i_clk);
      issue(m);
      chk_bit(mv, 1'b1, "no motion");
      chk_bit(dir, d0, "first direction");
      chk_bit(spd, s0, "first speed");
      chk_bit(busy, 1'b1, "not busy");
      chk_bit(done, 1'b0, "done not cleared");
      issue(6'h3f);
      for (n = 0; n < 40000 && org !== 1'b1; n++) begin
         ld = dir;
         ls = spd;
         @(negedge i_clk);
      end
      if (n == 40000) begin
         miscompares++;
         end_of_test();
      end
      chk_bit(mv, 1'b0, "still moving");
      chk_bit(busy, 1'b0, "still busy");
      chk_bit(done, 1'b1, "done missing");
      chk_bit(err, 1'b0, "busy command taken");
      chk_bit(ld, d1, "last direction");
      chk_bit(ls, s1, "last speed");
      chk_pos(lo, hi);
      @(negedge i_clk);
      chk_bit(org, 1'b0, "origin pulse too long");
      $display("test mode %0d done", m);
   endtask
   task automatic t_bad_mode();
      issue(6'h10);
      chk_bit(err, 1'b1, "low mode taken");
      chk_bit(mv, 1'b0, "low mode moved");
      issue(6'h1c);
      chk_bit(err, 1'b1, "high mode taken");
      $display("test bad mode done");
   endtask
   task automatic t_mode17();
      run_home(`MODE_17, 4000, 1'b0, 1'b1, 1'b1, 1'b0, 2001, 3000);
   endtask
   task automatic t_mode19();
      run_home(`MODE_19, 3000, 1'b1, 1'b1, 1'b0, 1'b0, 5000, 5999);
   endtask
   task automatic t_mode20();
      run_home(`MODE_20, 8000, 1'b0, 1'b0, 1'b1, 1'b0, 6000, 7000);
   endtask
   task automatic t_mode22();
      run_home(`MODE_22, 11000, 1'b0, 1'b1, 1'b0, 1'b1, 8500, 10000);
   endtask
   task automatic t_mode23();
      run_home(`MODE_23, 11000, 1'b1, 1'b1, 1'b0, 1'b0, 5000, 5999);
   endtask
   task automatic t_mode27();
      run_home(`MODE_27, 5000, 1'b0, 1'b1, 1'b1, 1'b0, 10001, 11000);
   endtask
   task automatic t_mode18();
      run_home(`MODE_18, 14500, 1'b0, 1'b0, 1'b0, 1'b0, 13000, 13999);
   endtask
   task automatic t_mode21();
      run_home(`MODE_21, 11000, 1'b0, 1'b1, 1'b1, 1'b0, 10001, 11000);
   endtask
   task automatic t_mode24();
      run_home(`MODE_24, 6500, 1'b0, 1'b0, 1'b1, 1'b0, 6000, 7000);
   endtask
   task automatic t_mode25();
      run_home(`MODE_25, 5500, 1'b1, 1'b1, 1'b0, 1'b0, 9000, 10000);
   endtask
   task automatic t_mode26();
      run_home(`MODE_26, 9500, 1'b1, 1'b0, 1'b1, 1'b0, 10001, 11000);
   endtask
   initial begin
      repeat (3) @(negedge i_clk);
      i_rst_n = 1'b1;
      repeat (1100) @(negedge i_clk);
      t_bad_mode();
      t_mode17();
      t_mode19();
      t_mode20();
      t_mode22();
      t_mode23();
      t_mode27();
      t_mode18();
      t_mode21();
      t_mode24();
      t_mode25();
      t_mode26();
      end_of_test();
   end
endmodule
`default_nettype wire
